//--- bench/mccr_config_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mccr_config_regs_asserts
  import mccr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // frame side
  input wire logic frame_valid,
  input wire logic frame_write,
  input wire logic [mccr_pkg::ADDR_W-1:0] frame_addr,
  input wire logic [mccr_pkg::DATA_W-1:0] frame_wdata,
  // answers and settings
  input wire logic rd_valid,
  input wire logic [1:0][12:0] lim_upper_ma,
  input wire logic [1:0][12:0] lim_lower_ma,
  input wire logic [1:0][8:0] open_thresh_ma,
  input wire mccr_pkg::mccr_slew_t [1:0] slew_mode,
  input wire logic [1:0] oc_auto_recover,
  input wire logic comm_loss,
  input wire logic outputs_hiz
);
  // ----
  // checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic w1;
  // ch1 write; settings land two edges on
  assign w1 = frame_valid && frame_write && frame_addr == ADDR_CH1_CFG;
  logic hold_q;
  logic [1:0] tmo_q;
  // mirror of the ch1 hold and timeout bits, built from writes seen on the frame side
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_q <= 1'b0;
      tmo_q <= 2'h0;
    end else if (w1) begin
      hold_q <= frame_wdata[BIT_LOSS_HOLD];
      tmo_q <= frame_wdata[BIT_TMO_HI:BIT_TMO_LO];
    end
  end
  rd_answer_a: assert property (frame_valid && !frame_write |=> rd_valid)
    else $error("read late");
  upper_sel_a: assert property (w1 |-> ##2
    lim_upper_ma[0] == ($past(frame_wdata[18], 2) ? 13'h11F8 : 13'h1964)) else $error("upper");
  lower_ofs_a: assert property (w1 |-> ##2 lim_upper_ma[0] - lim_lower_ma[0] ==
    ($past(frame_wdata[17], 2) ? 13'h01F4 : 13'h00FA)) else $error("lower");
  open_sel_a: assert property (w1 && frame_wdata[16:15] == 2'b10 |->
    ##2 open_thresh_ma[0] == 9'h12C) else $error("open");
  slew_sel_a: assert property (w1 && frame_wdata[14:12] == 3'b110 |->
    ##2 slew_mode[0] == MCCR_SLEW_FAST1) else $error("slew");
  oc_mode_a: assert property (w1 |-> ##2
    oc_auto_recover[0] == $past(frame_wdata[11], 2)) else $error("oc mode");
  kick_clr_a: assert property (frame_valid |=> !comm_loss) else $error("kick");
  hiz_gate_a: assert property (outputs_hiz == (comm_loss && !hold_q))
    else $error("hiz");
  never_loss_a: assert property (tmo_q == TMO_NEVER |-> !comm_loss)
    else $error("never");
  cover property (rd_valid);
  cover property (comm_loss && outputs_hiz);
  cover property (comm_loss && !outputs_hiz);
endmodule
bind mccr_config_regs mccr_config_regs_asserts u_chk (.clk, .rst, .frame_valid, .frame_write,
  .frame_addr, .frame_wdata, .rd_valid, .lim_upper_ma, .lim_lower_ma, .open_thresh_ma,
  .slew_mode, .oc_auto_recover, .comm_loss, .outputs_hiz);
`default_nettype wire

//--- bench/mccr_config_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mccr_config_regs_tb_top;
  import mccr_pkg::*;
  logic clk, rst, en, frame_valid, frame_write, rd_valid, comm_loss, outputs_hiz;
  logic [6:0] frame_addr;
  logic [31:0] frame_wdata, rd_data;
  logic [1:0][12:0] lim_upper_ma, lim_lower_ma;
  logic [1:0][8:0] open_thresh_ma;
  mccr_slew_t [1:0] slew_mode;
  logic [1:0] oc_auto_recover;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  // ----
  // design and host
  // ----
  mccr_config_regs #(.SHORT_CYC(8), .MID_CYC(16), .LONG_CYC(32)) DUT (.clk, .rst, .en,
    .frame_valid, .frame_write, .frame_addr, .frame_wdata, .rd_valid, .rd_data, .lim_upper_ma,
    .lim_lower_ma, .open_thresh_ma, .slew_mode, .oc_auto_recover, .comm_loss, .outputs_hiz);
  mccr_host_model host (.clk, .frame_valid, .frame_write, .frame_addr, .frame_wdata);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic edge1();
    @(posedge clk);
    #1;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    check("rst upper", lim_upper_ma[0], 13'h1964);
    host.xfer(1'b1, ADDR_CH1_CFG, 32'hFFFF_FFFF);
    host.xfer(1'b1, ADDR_CH2_CFG, 32'hFFFF_FFFF);
    host.xfer(1'b0, ADDR_CH1_CFG, 32'h0);
    #1;
    check("rd ch1", rd_data, MASK_CH1_CFG);
    check("rd valid", rd_valid, 1'b1);
    host.xfer(1'b0, ADDR_CH2_CFG, 32'h0);
    #1;
    check("rd ch2", rd_data, MASK_CH2_CFG);
    check("ch2 upper", lim_upper_ma[1], 13'h11F8);
    check("ch2 lower", lim_lower_ma[1], 13'h11F8 - 13'h01F4);
    check("ch2 open", open_thresh_ma[1], 9'h0C8);
    check("ch2 slew", slew_mode[1], MCCR_SLEW_NORMAL);
    check("ch2 oc", oc_auto_recover[1], 1'b1);
    host.xfer(1'b0, 7'h07, 32'h0);
    #1;
    check("rd none", rd_data, 32'h0);
  endtask
  // every open-load and slew code, both limit and recovery choices
  task automatic t_decode();
    logic [2:0] c;
    logic [12:0] up;
    logic [8:0] op [4] = '{9'h0C8, 9'h064, 9'h12C, 9'h0C8};
    mccr_slew_t sl [8] = '{MCCR_SLEW_NORMAL, MCCR_SLEW_SLOW1, MCCR_SLEW_SLOW2, MCCR_SLEW_SLOW3,
      MCCR_SLEW_SLOW4, MCCR_SLEW_FAST2, MCCR_SLEW_FAST1, MCCR_SLEW_NORMAL};
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      host.xfer(1'b1, ADDR_CH1_CFG, {13'h0, c[0], c[1], c[1:0], c, c[0], 2'b11, 9'h0});
      edge1();
      up = c[0] ? 13'h11F8 : 13'h1964;
      check("upper", lim_upper_ma[0], up);
      check("lower", lim_lower_ma[0], up - (c[1] ? 13'h01F4 : 13'h00FA));
      check("open", open_thresh_ma[0], op[c[1:0]]);
      check("slew", slew_mode[0], sl[c]);
      check("oc", oc_auto_recover[0], c[0]);
    end
  endtask
  // short limits 8/16/32 stand in for the real intervals
  task automatic t_timer();
    for (int t = 0; t < 3; t++) begin
      host.xfer(1'b1, ADDR_CH1_CFG, {21'h0, t[1:0], t[0], 8'h0});
      repeat ((8 << t) - 1) @(posedge clk);
      #1;
      check("early", comm_loss, 1'b0);
      edge1();
      check("loss", comm_loss, 1'b1);
      check("hiz", outputs_hiz, !t[0]);
    end
    host.xfer(1'b1, ADDR_CH1_CFG, 32'h0000_0600);
    repeat (64) @(posedge clk);
    #1;
    check("never", comm_loss, 1'b0);
  endtask
  // clock enable low freezes the loss timer mid-count
  task automatic t_freeze();
    host.xfer(1'b1, ADDR_CH1_CFG, 32'h0);
    @(posedge clk);
    en <= 1'b0;
    repeat (20) @(posedge clk);
    en <= 1'b1;
    #1;
    check("frozen", comm_loss, 1'b0);
    repeat (6) @(posedge clk);
    #1;
    check("thawed early", comm_loss, 1'b0);
    edge1();
    check("thawed loss", comm_loss, 1'b1);
  endtask
  // reset in mid-run clears loss, the ch2 decoded limits and the ch2 register
  task automatic t_rerst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check("rst loss", comm_loss, 1'b0);
    check("rst hiz", outputs_hiz, 1'b0);
    check("rst ch2 upper", lim_upper_ma[1], 13'h1964);
    check("rst ch2 lower", lim_lower_ma[1], 13'h1964 - 13'h00FA);
    host.xfer(1'b0, ADDR_CH2_CFG, 32'h0);
    #1;
    check("rst rd ch2", rd_data, 32'h0);
  endtask
  initial begin
    rst = 1'b1;
    en = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    edge1();
    t_regs();
    t_decode();
    t_timer();
    t_freeze();
    t_rerst();
    give_verdict();
  end
endmodule
`default_nettype wire

//--- bench/mccr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mccr_host_model (
  // clock
  input wire logic clk,
  // frame side
  output logic frame_valid,
  output logic frame_write,
  output logic [6:0] frame_addr,
  output logic [31:0] frame_wdata
);
  import mccr_pkg::*;
  // ----
  // one transfer per call
  // ----
  initial begin
    frame_valid = 1'b0;
    frame_write = 1'b0;
    frame_addr = 7'h00;
    frame_wdata = 32'h0000_0000;
  end
  // released fields show inverted junk so stale values never match
  task automatic xfer(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk);
    frame_valid <= 1'b1;
    frame_write <= w;
    frame_addr <= a;
    frame_wdata <= d;
    @(posedge clk);
    frame_valid <= 1'b0;
    frame_addr <= ~a;
    frame_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

//--- hw/mccr_comm_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module mccr_comm_watchdog
  import mccr_pkg::*;
#(
  parameter int unsigned SHORT_CYC = mccr_pkg::TMO_SHORT_CYC,
  parameter int unsigned MID_CYC = mccr_pkg::TMO_MID_CYC,
  parameter int unsigned LONG_CYC = mccr_pkg::TMO_LONG_CYC
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  // control
  input wire logic kick,
  input wire logic [1:0] tmo_sel,
  // status
  output logic loss
);

  logic [mccr_pkg::TMO_CNT_W-1:0] cnt_q, cnt_d, limit;
  logic loss_q, loss_d;

  // ----------------------------------------
  // limit select and counter
  // ----------------------------------------
  always_comb begin
    case (tmo_sel)
      TMO_SHORT: limit = TMO_CNT_W'(SHORT_CYC - 1);
      TMO_MID: limit = TMO_CNT_W'(MID_CYC - 1);
      TMO_LONG: limit = TMO_CNT_W'(LONG_CYC - 1);
      default: limit = '0;
    endcase
    cnt_d = cnt_q;
    loss_d = loss_q;
    if (kick) begin
      cnt_d = '0;
      loss_d = 1'b0;
    end else if (tmo_sel == TMO_NEVER) begin
      cnt_d = '0;
      loss_d = 1'b0;
    end else if (cnt_q >= limit) begin
      loss_d = 1'b1; // silence lasted the full interval
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // registers; counter saturates so loss stays until a kick
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      loss_q <= 1'b0;
    end else if (en) begin
      cnt_q <= cnt_d;
      loss_q <= loss_d;
    end
  end

  assign loss = loss_q;

endmodule
`default_nettype wire

//--- hw/mccr_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module mccr_config_regs #(
  parameter int unsigned SHORT_CYC = mccr_pkg::TMO_SHORT_CYC,
  parameter int unsigned MID_CYC = mccr_pkg::TMO_MID_CYC,
  parameter int unsigned LONG_CYC = mccr_pkg::TMO_LONG_CYC
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  // decoded serial frame
  input wire logic frame_valid,
  input wire logic frame_write,
  input wire logic [mccr_pkg::ADDR_W-1:0] frame_addr,
  input wire logic [mccr_pkg::DATA_W-1:0] frame_wdata,
  // read answer
  output logic rd_valid,
  output logic [mccr_pkg::DATA_W-1:0] rd_data,
  // per-channel settings, index 0 is channel one
  output logic [1:0][12:0] lim_upper_ma,
  output logic [1:0][12:0] lim_lower_ma,
  output logic [1:0][8:0] open_thresh_ma,
  output mccr_pkg::mccr_slew_t [1:0] slew_mode,
  output logic [1:0] oc_auto_recover,
  // communication loss
  output logic comm_loss,
  output logic outputs_hiz
);
  import mccr_pkg::*;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [31:0] ch1_cfg_q, ch1_cfg_d;
  logic [31:0] ch2_cfg_q, ch2_cfg_d;
  logic rd_valid_q, rd_valid_d;
  logic [31:0] rd_data_q, rd_data_d;
  logic hit_ch1, hit_ch2;
  logic [1:0][31:0] cfg;

  assign hit_ch1 = frame_addr == ADDR_CH1_CFG;
  assign hit_ch2 = frame_addr == ADDR_CH2_CFG;

  // masked writes; reserved bits never store, so they read zero
  always_comb begin
    ch1_cfg_d = ch1_cfg_q;
    ch2_cfg_d = ch2_cfg_q;
    rd_valid_d = 1'b0;
    rd_data_d = rd_data_q;
    if (frame_valid && frame_write && hit_ch1) begin
      ch1_cfg_d = (ch1_cfg_q & ~MASK_CH1_CFG) | (frame_wdata & MASK_CH1_CFG);
    end
    if (frame_valid && frame_write && hit_ch2) begin
      ch2_cfg_d = (ch2_cfg_q & ~MASK_CH2_CFG) | (frame_wdata & MASK_CH2_CFG);
    end
    if (frame_valid && !frame_write) begin
      rd_valid_d = 1'b1;
      if (hit_ch1) begin
        rd_data_d = ch1_cfg_q;
      end else if (hit_ch2) begin
        rd_data_d = ch2_cfg_q;
      end else begin
        rd_data_d = 32'h0000_0000; // unmapped reads zero
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ch1_cfg_q <= RST_CH1_CFG;
      ch2_cfg_q <= RST_CH2_CFG;
      rd_valid_q <= 1'b0;
      rd_data_q <= 32'h0000_0000;
    end else if (en) begin
      ch1_cfg_q <= ch1_cfg_d;
      ch2_cfg_q <= ch2_cfg_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign cfg[0] = ch1_cfg_q;
  assign cfg[1] = ch2_cfg_q;

  // ----------------------------------------
  // per-channel field decode
  // ----------------------------------------
  // decoded values are registered so the analog side sees clean levels
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic [12:0] upper_d, upper_q, lower_d, lower_q;
      logic [8:0] open_d, open_q;
      mccr_slew_t slew_d, slew_q;
      logic oc_d, oc_q;
      logic [1:0] open_code;
      logic [2:0] slew_code;

      assign open_code = cfg[ch][BIT_OPEN_HI:BIT_OPEN_LO];
      assign slew_code = cfg[ch][BIT_SLEW_HI:BIT_SLEW_LO];

      always_comb begin
        upper_d = cfg[ch][BIT_LIM_UPPER] ? LIM_UPPER_LO_MA : LIM_UPPER_HI_MA;
        lower_d = upper_d - (cfg[ch][BIT_LIM_LOWER] ?
                             LIM_OFS_LARGE_MA : LIM_OFS_SMALL_MA);
        case (open_code)
          2'h1: open_d = OPEN_LOW_MA;
          2'h2: open_d = OPEN_HIGH_MA;
          default: open_d = OPEN_MID_MA; // codes 00 and 11
        endcase
        case (slew_code)
          3'h1: slew_d = MCCR_SLEW_SLOW1;
          3'h2: slew_d = MCCR_SLEW_SLOW2;
          3'h3: slew_d = MCCR_SLEW_SLOW3;
          3'h4: slew_d = MCCR_SLEW_SLOW4;
          3'h5: slew_d = MCCR_SLEW_FAST2;
          3'h6: slew_d = MCCR_SLEW_FAST1;
          default: slew_d = MCCR_SLEW_NORMAL; // codes 000 and 111
        endcase
        oc_d = cfg[ch][BIT_OC_AUTO]; // 1 auto-recover, 0 latch
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          upper_q <= LIM_UPPER_HI_MA;
          lower_q <= LIM_UPPER_HI_MA - LIM_OFS_SMALL_MA;
          open_q <= OPEN_MID_MA;
          slew_q <= MCCR_SLEW_NORMAL;
          oc_q <= 1'b0;
        end else if (en) begin
          upper_q <= upper_d;
          lower_q <= lower_d;
          open_q <= open_d;
          slew_q <= slew_d;
          oc_q <= oc_d;
        end
      end

      assign lim_upper_ma[ch] = upper_q;
      assign lim_lower_ma[ch] = lower_q;
      assign open_thresh_ma[ch] = open_q;
      assign slew_mode[ch] = slew_q;
      assign oc_auto_recover[ch] = oc_q;
    end
  endgenerate

  // ----------------------------------------
  // communication-loss supervision
  // ----------------------------------------
  logic loss;

  // any valid frame counts as traffic, reads included
  mccr_comm_watchdog #(
    .SHORT_CYC(SHORT_CYC),
    .MID_CYC(MID_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_watchdog (
    .clk(clk),
    .rst(rst),
    .en(en),
    .kick(frame_valid),
    .tmo_sel(ch1_cfg_q[BIT_TMO_HI:BIT_TMO_LO]),
    .loss(loss)
  );

  assign comm_loss = loss;
  // hold mode keeps both bridges running as before the loss
  assign outputs_hiz = loss & ~ch1_cfg_q[BIT_LOSS_HOLD];

endmodule
`default_nettype wire

//--- hw/mccr_pkg.sv
// Overview of operation
// - bit 18 picks upper limit 6.5/4.6 A
// - bit 17 picks lower offset 0.25/0.5 A
// - bits 16:15 pick open-load threshold
// - bits 14:12 decode slew-rate mode
// - bit 11 picks latched or auto-recover over-current
// - bits 10:9 pick comm-loss timeout
// - timeout code 11 never declares loss
// - bit 8 picks outputs off or hold
// - second config register at address 0x05
package mccr_pkg;

  // ----------------------------------------
  // register addresses (frame address field)
  // ----------------------------------------
  localparam logic [6:0] ADDR_CH1_CFG = 7'h04;
  localparam logic [6:0] ADDR_CH2_CFG = 7'h05;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_LIM_UPPER = 18;
  localparam int BIT_LIM_LOWER = 17;
  localparam int BIT_OPEN_HI = 16;
  localparam int BIT_OPEN_LO = 15;
  localparam int BIT_SLEW_HI = 14;
  localparam int BIT_SLEW_LO = 12;
  localparam int BIT_OC_AUTO = 11;
  localparam int BIT_TMO_HI = 10;
  localparam int BIT_TMO_LO = 9;
  localparam int BIT_LOSS_HOLD = 8;

  // ----------------------------------------
  // writable masks and reset values
  // ----------------------------------------
  localparam logic [31:0] MASK_CH1_CFG = 32'h007F_FF00;
  localparam logic [31:0] MASK_CH2_CFG = 32'h0077_F800;
  localparam logic [31:0] RST_CH1_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_CH2_CFG = 32'h0000_0000;

  // ----------------------------------------
  // analog settings in milliamps
  // ----------------------------------------
  localparam logic [12:0] LIM_UPPER_HI_MA = 13'h1964; // 6500 mA
  localparam logic [12:0] LIM_UPPER_LO_MA = 13'h11F8; // 4600 mA
  localparam logic [12:0] LIM_OFS_SMALL_MA = 13'h00FA; // 250 mA
  localparam logic [12:0] LIM_OFS_LARGE_MA = 13'h01F4; // 500 mA
  localparam logic [8:0] OPEN_MID_MA = 9'h0C8; // 200 mA
  localparam logic [8:0] OPEN_LOW_MA = 9'h064; // 100 mA
  localparam logic [8:0] OPEN_HIGH_MA = 9'h12C; // 300 mA

  // ----------------------------------------
  // timeout codes and times
  // ----------------------------------------
  localparam logic [1:0] TMO_SHORT = 2'h0;
  localparam logic [1:0] TMO_MID = 2'h1;
  localparam logic [1:0] TMO_LONG = 2'h2;
  localparam logic [1:0] TMO_NEVER = 2'h3;
  localparam int CLK_FREQ_HZ = 125_000_000;
  localparam int TMO_SHORT_MS = 10;
  localparam int TMO_MID_MS = 100;
  localparam int TMO_LONG_MS = 1000;
  localparam int TMO_SHORT_CYC = CLK_FREQ_HZ / 1000 * TMO_SHORT_MS;
  localparam int TMO_MID_CYC = CLK_FREQ_HZ / 1000 * TMO_MID_MS;
  localparam int TMO_LONG_CYC = CLK_FREQ_HZ / 1000 * TMO_LONG_MS;
  localparam int TMO_CNT_W = 27;

  // ----------------------------------------
  // slew-rate modes
  // ----------------------------------------
  typedef enum logic [6:0] {
    MCCR_SLEW_NORMAL = 7'h01,
    MCCR_SLEW_SLOW1 = 7'h02,
    MCCR_SLEW_SLOW2 = 7'h04,
    MCCR_SLEW_SLOW3 = 7'h08,
    MCCR_SLEW_SLOW4 = 7'h10,
    MCCR_SLEW_FAST2 = 7'h20,
    MCCR_SLEW_FAST1 = 7'h40
  } mccr_slew_t;

endpackage
